// >>> rtl/adcsc_pkg.sv
// Shared constants for the dual-unit scan start controller.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package adcsc_pkg;
  // ***********************************************************
  // Register bit positions
  // ***********************************************************
  localparam int BIT_START = 7; // Scan start, acts on edges
  localparam int BIT_MODE = 6; // 0 single, 1 continuous
  localparam int BIT_IRQ_EN = 4; // Scan end interrupt enable
  localparam int BIT_TRG_EN = 1; // Hardware trigger enable
  localparam int BIT_TRG_SRC = 0; // 0 timer, 1 pin
  localparam logic [7:0] CTRL_WMASK = 8'hD3; // Writable bits
  localparam logic [7:0] CTRL_RESET = 8'h00; // Reset value
  // ***********************************************************
  // Software port map (designer's own)
  // ***********************************************************
  localparam logic [3:0] ADDR_CTRL_A = 4'h0; // Control unit A
  localparam logic [3:0] ADDR_CTRL_B = 4'h1; // Control unit B
  localparam logic [3:0] ADDR_STAT_A = 4'h2; // Status unit A
  localparam logic [3:0] ADDR_STAT_B = 4'h3; // Status unit B
  localparam logic [3:0] ADDR_CKS = 4'h4; // Conversion clock select
  localparam logic [3:0] ADDR_IRQ_EN_B = 4'h5; // Irq trigger enables B
  localparam int STAT_ACTIVE = 0; // Status bit: scan active
  localparam int STAT_END = 1; // Status bit: scan end flag
  localparam int STAT_BUSY = 2; // Status bit: irq conversion busy
  // ***********************************************************
  // Channel ranges and conversion timing in states
  // ***********************************************************
  localparam int CH_A_FIRST = 0; // First channel of unit A
  localparam int CH_A_LAST = 27; // Last channel of unit A
  localparam int CH_B_FIRST = 40; // First channel of unit B
  localparam int CH_B_LAST = 48; // Last channel of unit B
  localparam int CH_B_IRQ0 = 40; // First irq channel of unit B
  localparam int CH_B_IRQ1 = 44; // Second irq channel of unit B
  localparam int SCAN_STATES_SLOW = 56; // Scan of one channel, select 0
  localparam int SCAN_STATES_FAST = 28; // Scan of one channel, select 1
  localparam int IRQ_STATES_SLOW = 50; // Irq conversion, select 0
  localparam int IRQ_STATES_FAST = 25; // Irq conversion, select 1
  localparam int PIN_LOW_MIN_NS = 30; // Least pin low pulse, 1.5 periods
  localparam int CLK_NS = 20; // Clock period
  localparam int PIN_LOW_MIN_CYC = (PIN_LOW_MIN_NS + CLK_NS - 1) / CLK_NS; // Rounded up
  localparam int TIMER_PERIOD_SLOW = SCAN_STATES_SLOW + IRQ_STATES_SLOW * 2 + 8;
endpackage

// >>> rtl/adcsc_if.sv
// Carrier between the converter block and the trigger source end.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface adcsc_if (
  input wire logic clk // Common clock
);
  logic timer_trig_a; // Timer channel pulse for unit A
  logic timer_trig_b; // Timer channel pulse for unit B
  logic irq_trig_a; // Channel 0 interrupt trigger pulse
  logic irq_trig_b; // Channels 40/44 interrupt trigger pulse
  logic ext_trigger_pin_unit_a; // Pin trigger A, idles high
  logic ext_trigger_pin_unit_b; // Pin trigger B, idles high
  logic scan_end_interrupt_a; // Scan end interrupt A
  logic scan_end_interrupt_b; // Scan end interrupt B
  modport device (
    input timer_trig_a, timer_trig_b, irq_trig_a, irq_trig_b,
    input ext_trigger_pin_unit_a, ext_trigger_pin_unit_b,
    output scan_end_interrupt_a, scan_end_interrupt_b
  );
  modport source (
    output timer_trig_a, timer_trig_b, irq_trig_a, irq_trig_b,
    output ext_trigger_pin_unit_a, ext_trigger_pin_unit_b,
    input scan_end_interrupt_a, scan_end_interrupt_b
  );
endinterface

// >>> rtl/adcsc_device.sv
// Scan start control for two converter units, A and B.
// Assumes synchronous trigger inputs and software on a plain port.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module adcsc_device (
  input wire logic clk, // 50 MHz clock
  input wire logic reset, // Synchronous reset, active high
  adcsc_if.device link, // Trigger and interrupt side
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after strobe
  output logic [5:0] channel_a, // Channel converting on unit A
  output logic [5:0] channel_b // Channel converting on unit B
);
  // ***********************************************************
  // Types and state
  // ***********************************************************
  typedef enum logic [1:0] {ADCSC_IDLE, ADCSC_IRQ, ADCSC_SCAN} adcsc_phase_t;
  typedef struct packed {
    adcsc_phase_t phase; // What the unit is doing
    logic [7:0] ctrl; // Control register
    logic active; // Scan active flag
    logic end_flag; // Scan end flag
    logic pend_scan; // Scan waiting behind irq conversions
    logic [1:0] irq_left; // Irq conversions still to run
    logic [5:0] chan; // Current channel
    logic [5:0] count; // States left in this conversion
    logic pin_q; // Last sampled pin level
  } adcsc_unit_t;
  typedef struct packed {
    adcsc_unit_t a; // Unit A
    adcsc_unit_t b; // Unit B
    logic conversion_clock_select; // Conversion clock select
    logic [1:0] irq_en_b; // Enables for ch40 and ch44
    logic [7:0] rdata; // Read data register
    logic irq_a; // Interrupt A
    logic irq_b; // Interrupt B
  } adcsc_state_t;
  adcsc_state_t s, next_s;

  // Conversion length in states for the current clock select
  function automatic logic [5:0] conv_len(input logic irq, input logic conversion_clock_select);
    if (irq) begin
      conv_len = conversion_clock_select ? 6'(adcsc_pkg::IRQ_STATES_FAST) : 6'(adcsc_pkg::IRQ_STATES_SLOW);
    end else begin
      conv_len = conversion_clock_select ? 6'(adcsc_pkg::SCAN_STATES_FAST) : 6'(adcsc_pkg::SCAN_STATES_SLOW);
    end
  endfunction

  // Status byte of one unit
  function automatic logic [7:0] status(input adcsc_unit_t u);
    status = 8'h00;
    status[adcsc_pkg::STAT_ACTIVE] = u.active;
    status[adcsc_pkg::STAT_END] = u.end_flag;
    status[adcsc_pkg::STAT_BUSY] = (u.phase == ADCSC_IRQ);
  endfunction

  // One unit's next state. Scan covers first..last channels; irq channels
  // are held in irq_ch0/irq_ch1 and run ahead of a scan started alongside.
  function automatic adcsc_unit_t step(
    input adcsc_unit_t u, input logic wr_ctrl, input logic [7:0] wval,
    input logic clr_end, input logic timer, input logic pin,
    input logic irq_trig, input logic [1:0] irq_en, input logic conversion_clock_select,
    input logic [5:0] first, input logic [5:0] last,
    input logic [5:0] irq_ch0, input logic [5:0] irq_ch1);
    adcsc_unit_t n;
    logic [7:0] nc;
    logic start;
    logic stop;
    logic done;
    n = u;
    nc = u.ctrl;
    if (wr_ctrl) begin
      nc = wval & adcsc_pkg::CTRL_WMASK;
    end
    n.ctrl = nc;
    n.pin_q = pin;
    start = 1'b0;
    if (!u.ctrl[adcsc_pkg::BIT_START] && nc[adcsc_pkg::BIT_START]) begin
      start = 1'b1;
    end
    if (u.ctrl[adcsc_pkg::BIT_TRG_EN]) begin
      if (u.ctrl[adcsc_pkg::BIT_TRG_SRC]) begin
        start = start | (u.pin_q & ~pin);
      end else begin
        start = start | timer;
      end
    end
    stop = (u.ctrl[adcsc_pkg::BIT_START] && !nc[adcsc_pkg::BIT_START])
      || (u.ctrl[adcsc_pkg::BIT_MODE] && !nc[adcsc_pkg::BIT_MODE] && u.active);
    if (clr_end) begin
      n.end_flag = 1'b0;
    end
    done = (u.count == 6'h01);
    case (u.phase)
      ADCSC_IDLE: begin
        if (irq_trig && irq_en != 2'h0) begin
          n.phase = ADCSC_IRQ;
          n.irq_left = irq_en;
          n.chan = irq_en[0] ? irq_ch0 : irq_ch1;
          n.count = conv_len(1'b1, conversion_clock_select);
          n.pend_scan = start;
          n.active = start;
        end else if (start) begin
          n.phase = ADCSC_SCAN;
          n.active = 1'b1;
          n.chan = first;
          n.count = conv_len(1'b0, conversion_clock_select);
        end
      end
      ADCSC_IRQ: begin
        if (stop) begin
          n.pend_scan = 1'b0;
          n.active = 1'b0;
        end else if (start && !u.active) begin
          n.pend_scan = 1'b1;
          n.active = 1'b1;
        end
        if (done) begin
          if (u.irq_left == 2'h3 && u.chan == irq_ch0) begin
            n.irq_left = 2'h2;
            n.chan = irq_ch1;
            n.count = conv_len(1'b1, conversion_clock_select);
          end else if (n.pend_scan) begin
            n.phase = ADCSC_SCAN;
            n.pend_scan = 1'b0;
            n.irq_left = 2'h0;
            n.chan = first;
            n.count = conv_len(1'b0, conversion_clock_select);
          end else begin
            n.phase = ADCSC_IDLE;
            n.irq_left = 2'h0;
          end
        end else begin
          n.count = u.count - 6'h01;
        end
      end
      ADCSC_SCAN: begin
        if (stop) begin
          n.phase = ADCSC_IDLE;
          n.active = 1'b0;
        end else if (done) begin
          if (u.chan == last) begin
            n.end_flag = 1'b1;
            if (u.ctrl[adcsc_pkg::BIT_MODE]) begin
              n.chan = first;
              n.count = conv_len(1'b0, conversion_clock_select);
            end else begin
              n.phase = ADCSC_IDLE;
              n.active = 1'b0;
            end
          end else begin
            n.chan = u.chan + 6'h01;
            n.count = conv_len(1'b0, conversion_clock_select);
          end
        end else begin
          n.count = u.count - 6'h01;
        end
      end
      default: begin
        n.phase = ADCSC_IDLE;
      end
    endcase
    step = n;
  endfunction

  // ***********************************************************
  // Next-state logic
  // ***********************************************************
  // Both units step in the same cycle so simultaneous timer pulses align
  always_comb begin
    next_s = s;
    next_s.a = step(s.a, wr && addr == adcsc_pkg::ADDR_CTRL_A, wdata,
      wr && addr == adcsc_pkg::ADDR_STAT_A && !wdata[adcsc_pkg::STAT_END],
      link.timer_trig_a, link.ext_trigger_pin_unit_a, link.irq_trig_a, 2'h1, s.conversion_clock_select,
      6'(adcsc_pkg::CH_A_FIRST), 6'(adcsc_pkg::CH_A_LAST),
      6'(adcsc_pkg::CH_A_FIRST), 6'(adcsc_pkg::CH_A_FIRST));
    next_s.b = step(s.b, wr && addr == adcsc_pkg::ADDR_CTRL_B, wdata,
      wr && addr == adcsc_pkg::ADDR_STAT_B && !wdata[adcsc_pkg::STAT_END],
      link.timer_trig_b, link.ext_trigger_pin_unit_b, link.irq_trig_b, s.irq_en_b, s.conversion_clock_select,
      6'(adcsc_pkg::CH_B_FIRST), 6'(adcsc_pkg::CH_B_LAST),
      6'(adcsc_pkg::CH_B_IRQ0), 6'(adcsc_pkg::CH_B_IRQ1));
    // Irq enables: completion is kept if interrupt enable is on, set wins
    next_s.irq_a = next_s.a.end_flag & next_s.a.ctrl[adcsc_pkg::BIT_IRQ_EN];
    next_s.irq_b = next_s.b.end_flag & next_s.b.ctrl[adcsc_pkg::BIT_IRQ_EN];
    if (wr && addr == adcsc_pkg::ADDR_CKS) begin
      next_s.conversion_clock_select = wdata[0];
    end
    if (wr && addr == adcsc_pkg::ADDR_IRQ_EN_B) begin
      next_s.irq_en_b = wdata[1:0];
    end
    next_s.rdata = 8'h00;
    if (rd) begin
      case (addr)
        adcsc_pkg::ADDR_CTRL_A: next_s.rdata = s.a.ctrl;
        adcsc_pkg::ADDR_CTRL_B: next_s.rdata = s.b.ctrl;
        adcsc_pkg::ADDR_STAT_A: next_s.rdata = status(s.a);
        adcsc_pkg::ADDR_STAT_B: next_s.rdata = status(s.b);
        adcsc_pkg::ADDR_CKS: next_s.rdata = {7'h00, s.conversion_clock_select};
        adcsc_pkg::ADDR_IRQ_EN_B: next_s.rdata = {6'h00, s.irq_en_b};
        default: next_s.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
    if (reset) begin
      next_s = '0;
      next_s.a.ctrl = adcsc_pkg::CTRL_RESET;
      next_s.b.ctrl = adcsc_pkg::CTRL_RESET;
      next_s.a.pin_q = 1'b1; // Pin idles high; no false edge after reset
      next_s.b.pin_q = 1'b1;
    end
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign rdata = s.rdata;
  assign channel_a = s.a.chan;
  assign channel_b = s.b.chan;
  assign link.scan_end_interrupt_a = s.irq_a;
  assign link.scan_end_interrupt_b = s.irq_b;
endmodule

// >>> rtl/adcsc_source.sv
// Trigger source end: timer channel pulses, irq triggers, pin pulses.
// Assumes shares clk with the converter end; user asks by one-cycle strobes.
`timescale 1ns/1ps
module adcsc_source #(
  parameter int PIN_LOW_CYC = adcsc_pkg::PIN_LOW_MIN_CYC // Low pulse length
) (
  input wire logic clk, // 50 MHz clock
  input wire logic reset, // Synchronous reset, active high
  adcsc_if.source link, // Converter side
  input wire logic go_timer_a, // Pulse timer trigger A
  input wire logic go_timer_b, // Pulse timer trigger B
  input wire logic go_irq_a, // Pulse irq trigger A
  input wire logic go_irq_b, // Pulse irq trigger B
  input wire logic go_pin_a, // Start low pulse on pin A
  input wire logic go_pin_b, // Start low pulse on pin B
  output logic irq_seen_a, // Interrupt A level, registered
  output logic irq_seen_b // Interrupt B level, registered
);
  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic [3:0] trig; // Timer A, timer B, irq A, irq B pulses
    logic [7:0] low_a; // Cycles of low left on pin A
    logic [7:0] low_b; // Cycles of low left on pin B
    logic [1:0] seen; // Interrupt levels
  } adcsc_src_t;
  adcsc_src_t s, next_s;

  // Pin holds high except during a counted low pulse
  always_comb begin
    next_s = s;
    next_s.trig = {go_timer_a, go_timer_b, go_irq_a, go_irq_b};
    if (s.low_a != 8'h00) begin
      next_s.low_a = s.low_a - 8'h01;
    end else if (go_pin_a) begin
      next_s.low_a = 8'(PIN_LOW_CYC);
    end
    if (s.low_b != 8'h00) begin
      next_s.low_b = s.low_b - 8'h01;
    end else if (go_pin_b) begin
      next_s.low_b = 8'(PIN_LOW_CYC);
    end
    next_s.seen = {link.scan_end_interrupt_a, link.scan_end_interrupt_b};
    if (reset) begin
      next_s = '0;
    end
  end

  // Register the whole state
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign link.timer_trig_a = s.trig[3];
  assign link.timer_trig_b = s.trig[2];
  assign link.irq_trig_a = s.trig[1];
  assign link.irq_trig_b = s.trig[0];
  assign link.ext_trigger_pin_unit_a = (s.low_a == 8'h00);
  assign link.ext_trigger_pin_unit_b = (s.low_b == 8'h00);
  assign irq_seen_a = s.seen[1];
  assign irq_seen_b = s.seen[0];
endmodule

// >>> verif/adcsc_asserts.sv
// Checker on the carrier between the converter end and the source end.
// Assumes one clock; it sees only reset and the carrier's signals.
`timescale 1ns/1ps
module adcsc_asserts (
  input wire logic clk, // Common clock
  input wire logic reset, // Synchronous reset
  input wire logic timer_trig_a, // Timer pulse A
  input wire logic timer_trig_b, // Timer pulse B
  input wire logic irq_trig_a, // Irq trigger A
  input wire logic irq_trig_b, // Irq trigger B
  input wire logic ext_trigger_pin_unit_a, // Pin trigger A
  input wire logic ext_trigger_pin_unit_b, // Pin trigger B
  input wire logic scan_end_interrupt_a, // Interrupt A
  input wire logic scan_end_interrupt_b // Interrupt B
);
  // ****
  // Properties
  // ****
  // Reset masks every check, so a second reset cannot leave stale history
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_RESET_IDLE: assert property ($fell(reset) |-> ext_trigger_pin_unit_a &&
    ext_trigger_pin_unit_b && !scan_end_interrupt_a && !scan_end_interrupt_b)
    else $error("carrier not idle after reset");
  AST_PIN_A_WIDTH: assert property ($fell(ext_trigger_pin_unit_a) |=>
    !ext_trigger_pin_unit_a) else $error("pin A low pulse too short");
  AST_PIN_B_WIDTH: assert property ($fell(ext_trigger_pin_unit_b) |=>
    !ext_trigger_pin_unit_b) else $error("pin B low pulse too short");
  // A pin stuck low would block every later falling edge
  AST_PIN_A_BACK: assert property ($fell(ext_trigger_pin_unit_a) |->
    ##[2:8] ext_trigger_pin_unit_a) else $error("pin A stays low");
  AST_PIN_B_BACK: assert property ($fell(ext_trigger_pin_unit_b) |->
    ##[2:8] ext_trigger_pin_unit_b) else $error("pin B stays low");
  AST_TIMER_A_PULSE: assert property (timer_trig_a |=> !timer_trig_a)
    else $error("timer pulse A longer than a cycle");
  AST_TIMER_B_PULSE: assert property (timer_trig_b |=> !timer_trig_b)
    else $error("timer pulse B longer than a cycle");
  AST_IRQ_A_PULSE: assert property (irq_trig_a |=> !irq_trig_a)
    else $error("irq trigger A longer than a cycle");
  AST_IRQ_B_PULSE: assert property (irq_trig_b |=> !irq_trig_b)
    else $error("irq trigger B longer than a cycle");
  AST_END_B_HOLDS: assert property ($rose(scan_end_interrupt_b) |=>
    scan_end_interrupt_b) else $error("interrupt B dropped by itself");
  // Main scenarios
  cover property (timer_trig_a && timer_trig_b);
  cover property (timer_trig_b && irq_trig_b);
  cover property ($rose(scan_end_interrupt_b));
endmodule

// >>> verif/testbench.sv
// Testbench joining the converter end to the trigger source end.
// Assumes package and carrier compile first; one 50 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0; // Clock
  logic reset = 1'b1; // Reset, held at start
  logic [3:0] addr = 4'h0; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [5:0] go = 6'h00; // Strobes: timer a/b, irq a/b, pin a/b
  logic [7:0] rdata; // Read data
  logic [5:0] channel_a; // Channel on A
  logic [5:0] channel_b; // Channel on B
  logic irq_seen_a; // Interrupt copy A
  logic irq_seen_b; // Interrupt copy B
  int miscompares = 0; // Mismatch count
  int tests_run = 0; // Comparison count
  logic [31:0] seed = 32'h57B6EFCF; // Xorshift state
  int nch [2] = '{28, 9}; // Channels per unit
  logic [7:0] tctl [6] = '{8'h02, 8'h02, 8'h03, 8'h03, 8'h01, 8'h00}; // Trigger setups
  bit tpin [6] = '{0, 1, 1, 0, 1, 0}; // Pin or timer pulse
  bit texp [6] = '{1, 0, 1, 0, 0, 0}; // Scan expected
  always #10 clk = ~clk;
  adcsc_if link (.clk(clk));
  adcsc_device u_adcsc_device (.clk(clk), .reset(reset), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .channel_a(channel_a),
    .channel_b(channel_b));
  adcsc_source u_adcsc_source (.clk(clk), .reset(reset), .link(link),
    .go_timer_a(go[0]), .go_timer_b(go[1]), .go_irq_a(go[2]), .go_irq_b(go[3]),
    .go_pin_a(go[4]), .go_pin_b(go[5]), .irq_seen_a(irq_seen_a), .irq_seen_b(irq_seen_b));
  adcsc_asserts u_adcsc_asserts (.clk(clk), .reset(reset),
    .timer_trig_a(link.timer_trig_a), .timer_trig_b(link.timer_trig_b),
    .irq_trig_a(link.irq_trig_a), .irq_trig_b(link.irq_trig_b),
    .ext_trigger_pin_unit_a(link.ext_trigger_pin_unit_a),
    .ext_trigger_pin_unit_b(link.ext_trigger_pin_unit_b),
    .scan_end_interrupt_a(link.scan_end_interrupt_a),
    .scan_end_interrupt_b(link.scan_end_interrupt_b));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes are dropped at the taking edge, so calls never collide
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask
  // Device takes the pulse two edges after this call's first edge
  task automatic fire(input logic [5:0] m);
    @(posedge clk);
    go <= m;
    @(posedge clk);
    go <= 6'h00;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog well above the roughly 8000 cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // ****
  // Sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(4'(i), 8'h00);
    rd_chk(4'hF, 8'h00);
    // Random settings while idle; start bit kept low
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr_reg(4'(i % 2), seed[7:0] & 8'h7F);
      rd_chk(4'(i % 2), seed[7:0] & 8'h53);
    end
    wr_reg(adcsc_pkg::ADDR_CTRL_A, 8'h00);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h00);
    // Slow clock select: a unit A irq conversion stays busy for 50 states
    fire(6'h04);
    wait_n(46);
    rd_chk(adcsc_pkg::ADDR_STAT_A, 8'h04);
    wait_n(4);
    rd_chk(adcsc_pkg::ADDR_STAT_A, 8'h00);
    wr_reg(adcsc_pkg::ADDR_CKS, 8'h01);
    // Single scan on B by the start bit, interrupt enabled
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h90);
    for (int k = 0; k < 9; k++) begin
      wait_n(k == 0 ? 1 : 28);
      check(channel_b, 8'(40 + k));
    end
    wait_n(30);
    check(link.scan_end_interrupt_b, 8'h01);
    rd_chk(adcsc_pkg::ADDR_STAT_B, 8'h02);
    wr_reg(adcsc_pkg::ADDR_STAT_B, 8'h00);
    wait_n(2);
    check(link.scan_end_interrupt_b, 8'h00);
    // Timer pulse while active is dropped; start bit fall stops the scan
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h00);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h82);
    fire(6'h02);
    wait_n(4);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h02);
    wait_n(5);
    rd_chk(adcsc_pkg::ADDR_STAT_B, 8'h00);
    // Trigger enable and source select on both units
    for (int u = 0; u < 2; u++) begin
      for (int t = 0; t < 6; t++) begin
        wr_reg(4'(u), tctl[t]);
        fire(tpin[t] ? (6'h10 << u) : (6'h01 << u));
        wait_n(2);
        rd_chk(4'(2 + u), {7'h00, texp[t]});
        wait_n(nch[u] * 28 + 4);
        wr_reg(4'(2 + u), 8'h00);
      end
    end
    // Both timers together; start rise while active is ignored, fall stops
    wr_reg(adcsc_pkg::ADDR_CTRL_A, 8'h02);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h02);
    fire(6'h03);
    wait_n(2);
    check(channel_a, 8'h00);
    check(channel_b, 8'h28);
    for (int u = 0; u < 2; u++) begin
      wr_reg(4'(u), 8'h82);
      wr_reg(4'(u), 8'h02);
      rd_chk(4'(2 + u), 8'h00);
    end
    // Irq conversions run before a scan triggered in the same cycle
    wr_reg(adcsc_pkg::ADDR_CTRL_A, 8'h12);
    wr_reg(adcsc_pkg::ADDR_IRQ_EN_B, 8'h03);
    fire(6'h0F);
    wait_n(2);
    check(channel_a, 8'h00);
    check(channel_b, 8'h28);
    wait_n(25);
    check(channel_b, 8'h2C);
    wait_n(26);
    check(channel_a, 8'h00);
    check(channel_b, 8'h28);
    // Unit A channel 0 scan slot ends 25 + 28 states after the trigger
    wait_n(2);
    check(channel_a, 8'h01);
    wait_n(25);
    check(channel_b, 8'h29);
    wait_n(800);
    check(irq_seen_a, 8'h01);
    wr_reg(adcsc_pkg::ADDR_STAT_A, 8'h00);
    wr_reg(adcsc_pkg::ADDR_STAT_B, 8'h00);
    // Continuous scan on B wraps, then the mode bit stops it
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'hD0);
    wait_n(254);
    check(channel_b, 8'h28);
    check(link.scan_end_interrupt_b, 8'h01);
    rd_chk(adcsc_pkg::ADDR_STAT_B, 8'h03);
    check(irq_seen_a, 8'h00);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h90);
    rd_chk(adcsc_pkg::ADDR_STAT_B, 8'h02);
    check(irq_seen_b, 8'h01);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h80);
    wait_n(2);
    check(link.scan_end_interrupt_b, 8'h00);
    close_out();
  end
endmodule
